// ===== cct_map.svh
`ifndef CCT_MAP_SVH
`define CCT_MAP_SVH
// ****************************************
// Address decode
// ****************************************
`define CCT_BASE_BLK 4'h2
`define CCT_BASE_NBLK 4'h3
// ****************************************
// Register offsets
// ****************************************
`define CCT_OFS_DIR 8'h20
`define CCT_OFS_FORCE 8'h21
`define CCT_OFS_OVR_MASK 8'h22
`define CCT_OFS_OVR_DATA 8'h23
`define CCT_OFS_CNT_HI 8'h24
`define CCT_OFS_CNT_LO 8'h25
`define CCT_OFS_CTRL1 8'h26
`define CCT_OFS_TOV 8'h27
`define CCT_OFS_ACT 8'h28
`define CCT_OFS_EDGE 8'h29
`define CCT_OFS_CHMASK 8'h2a
`define CCT_OFS_CTRL2 8'h2b
`define CCT_OFS_CHFLG 8'h2c
`define CCT_OFS_OVFLG 8'h2d
`define CCT_OFS_CMP_FIRST 8'h2e
`define CCT_OFS_CMP_LAST 8'h35
// ****************************************
// Field positions
// ****************************************
`define CCT_BIT_RUN 7
`define CCT_BIT_OVIE 7
`define CCT_BIT_OVF 7
// ****************************************
// Reset values
// ****************************************
`define CCT_RST_BYTE 8'h00
`define CCT_RST_CNT 16'h0000
`endif

// ===== cct_pin_model.sv
`timescale 1ns/1ps
// ****************************************
// External capture pins
// ****************************************
module cct_pin_model (
  input wire logic i_core_clk,
  input wire logic [3:0] i_level,
  output logic [3:0] o_cc_pin
);
  // capture source pins
  // Pins start low so the synchroniser never sees an unknown,
  // then change only just after a clock edge
  initial
  begin
    o_cc_pin = 4'h0;
    forever
    begin
      @(posedge i_core_clk);
      o_cc_pin <= i_level;
    end
  end
endmodule

// ===== cct_pkg.sv
package cct_pkg;
  // Whole state of the timer, registered as one word
  typedef struct packed {
    logic [15:0] cnt;
    logic [7:0] pre;
    logic [3:0][15:0] cval;
    logic [3:0] dir;
    logic [3:0] ovr_mask;
    logic [3:0] ovr_data;
    logic run;
    logic [3:0] tov;
    logic [7:0] act;
    logic [7:0] edge_sel;
    logic [3:0] chmask;
    logic ovie;
    logic [2:0] pr;
    logic [3:0] chflg;
    logic ovflg;
    logic [3:0] port;
    logic [3:0] oe;
    logic [15:0] rdata;
    logic irq;
    logic [3:0] pin_s1;
    logic [3:0] pin_s2;
    logic [3:0] pin_prev;
    logic spc_s1;
    logic spc_s2;
  } cct_state_t;
endpackage

// ===== cct_timer.sv
`timescale 1ns/1ps
`include "cct_map.svh"
// Functional notes
// R1: Direction bit 0 capture, 1 compare
// R2: Force bit fires action, no flag
// R3: Force register reads zero, stores nothing
// R4: Force with match wins, flag clear
// R5: Channel 3 match overrides masked pins
// R6: Mask bit drives pin when compare
// R7: Channel 3 match copies data bits
// R8: 16-bit up counter, high byte first
// R9: Counter read anytime, written special mode
// R10: Word access reaches counter in one cycle
// R11: Counter write leaves prescaler running
// R12: Compare value write ignored in capture
// R13: Block seen at both bases
// R14: Action bits: off, toggle, low, high
// R15: Wrap toggle beats forced action
// R16: Run enable starts and stops timer
// R17: Tick increments, wrap flags overflow
// R18: Compare match sets flag, acts
module cct_timer (
  input wire logic i_core_clk,
  input wire logic i_resetn,
  input wire logic [11:0] i_addr,
  input wire logic i_word,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic i_special_mode,
  input wire logic [3:0] i_cc_pin,
  output logic [15:0] o_rdata,
  output logic [3:0] o_cc_pin,
  output logic [3:0] o_cc_pin_oe,
  output logic o_irq
);
  import cct_pkg::*;

  // ****************************************
  // State and per-cycle events
  // ****************************************
  cct_state_t s_q; // Registered state
  cct_state_t s_d; // Next state
  logic tick; // Prescaler period done
  logic ovf; // Counter wraps this cycle
  logic [3:0] match; // Real compare match
  logic [3:0] cap; // Capture edge seen
  logic [3:0] fpulse; // Force bits written this cycle
  logic blk_sel; // Access hits the block
  logic cnt_wr; // Counter write accepted

  // ****************************************
  // Helper functions
  // ****************************************
  // Read one byte of the register image
  function automatic logic [7:0] rd_byte(input cct_state_t s, input logic [7:0] ofs);
    logic [7:0] v;
    logic [2:0] idx;
    v = 8'h00;
    idx = 3'(ofs - `CCT_OFS_CMP_FIRST);
    case (ofs)
      `CCT_OFS_DIR: v = {4'h0, s.dir};
      `CCT_OFS_OVR_MASK: v = {4'h0, s.ovr_mask};
      `CCT_OFS_OVR_DATA: v = {4'h0, s.ovr_data};
      `CCT_OFS_CNT_HI: v = s.cnt[15:8];
      `CCT_OFS_CNT_LO: v = s.cnt[7:0];
      `CCT_OFS_CTRL1: v = {s.run, 7'h00};
      `CCT_OFS_TOV: v = {4'h0, s.tov};
      `CCT_OFS_ACT: v = s.act;
      `CCT_OFS_EDGE: v = s.edge_sel;
      `CCT_OFS_CHMASK: v = {4'h0, s.chmask};
      `CCT_OFS_CTRL2: v = {s.ovie, 4'h0, s.pr};
      `CCT_OFS_CHFLG: v = {4'h0, s.chflg};
      `CCT_OFS_OVFLG: v = {s.ovflg, 7'h00};
      default:
      begin
        // Compare values, high byte at even offset
        if (ofs >= `CCT_OFS_CMP_FIRST && ofs <= `CCT_OFS_CMP_LAST)
          v = idx[0] ? s.cval[idx[2:1]][7:0] : s.cval[idx[2:1]][15:8];
      end
    endcase
    return v;
  endfunction

  // Apply a programmed output action to a pin level
  function automatic logic act_apply(input logic lvl, input logic [1:0] a);
    logic r;
    r = lvl;
    // R14 action encoding
    case (a)
      2'b01: r = ~lvl;
      2'b10: r = 1'b0;
      2'b11: r = 1'b1;
      default: r = lvl;
    endcase
    return r;
  endfunction

  // ****************************************
  // Next-state logic
  // ****************************************
  always_comb
  begin
    logic [7:0] ofs;
    logic [7:0] bofs;
    logic [7:0] bval;
    logic [2:0] ti;
    logic [7:0] plim;
    logic [15:0] cnt_nx;
    logic [3:0] pin;
    logic [3:0] rise;
    logic [3:0] fall;
    ofs = i_addr[7:0];
    cnt_nx = 16'h0000;
    pin = 4'h0;
    rise = 4'h0;
    fall = 4'h0;
    bofs = 8'h00;
    bval = 8'h00;
    ti = 3'h0;
    plim = 8'((9'h001 << s_q.pr) - 9'h001);
    s_d = s_q;
    // Pin and mode synchronisers
    s_d.pin_s1 = i_cc_pin;
    s_d.pin_s2 = s_q.pin_s1;
    s_d.pin_prev = s_q.pin_s2;
    s_d.spc_s1 = i_special_mode;
    s_d.spc_s2 = s_q.spc_s1;
    // R13 same offsets at either base
    blk_sel = (i_addr[11:8] == `CCT_BASE_BLK) || (i_addr[11:8] == `CCT_BASE_NBLK);
    // R16 prescaler and counter run only when enabled
    tick = 1'b0;
    if (s_q.run)
    begin
      // R11 prescaler free of counter writes
      if (s_q.pre >= plim)
      begin
        s_d.pre = 8'h00;
        tick = 1'b1;
      end
      else
        s_d.pre = s_q.pre + 8'h01;
    end
    // R17 increment and wrap
    cnt_nx = s_q.cnt + 16'(tick);
    ovf = tick && (s_q.cnt == 16'hffff);
    s_d.cnt = cnt_nx;
    // R1 capture on selected edges for input channels
    rise = s_q.pin_s2 & ~s_q.pin_prev;
    fall = ~s_q.pin_s2 & s_q.pin_prev;
    for (int n = 0; n < 4; n++)
    begin
      cap[n] = !s_q.dir[n] && ((s_q.edge_sel[2*n] && rise[n]) || (s_q.edge_sel[2*n+1] && fall[n]));
      // R18 match when the counter steps onto the value
      match[n] = s_q.dir[n] && tick && (cnt_nx == s_q.cval[n]);
    end
    // R2 force pulse, R3 never stored
    fpulse = 4'h0;
    if (blk_sel && i_wr && ofs == `CCT_OFS_FORCE)
      fpulse = i_wdata[3:0] & s_q.dir;
    // Compare actions, channels 0 to 3
    pin = s_q.port;
    for (int n = 0; n < 4; n++)
    begin
      // R2 forced action same as match
      if (match[n] || fpulse[n])
        pin[n] = act_apply(pin[n], s_q.act[2*n+:2]);
    end
    // R5 R7 channel 3 overrides masked pins
    if (match[3] || fpulse[3])
    begin
      for (int n = 0; n < 4; n++)
      begin
        if (s_q.ovr_mask[n] && s_q.dir[n])
          pin[n] = s_q.ovr_data[n];
      end
    end
    // R15 wrap toggle wins over forced action
    for (int n = 0; n < 4; n++)
    begin
      if (ovf && s_q.tov[n] && s_q.dir[n])
        pin[n] = ~s_q.port[n];
    end
    s_d.port = pin;
    // R6 output drive for compare channels
    s_d.oe = s_q.dir & (s_q.ovr_mask |
      {|s_q.act[7:6], |s_q.act[5:4], |s_q.act[3:2], |s_q.act[1:0]});
    // Register writes
    cnt_wr = 1'b0;
    if (blk_sel && i_wr)
    begin
      for (int k = 0; k < 2; k++)
      begin
        if (k == 0 || i_word)
        begin
          bofs = ofs + 8'(k);
          bval = (i_word && k == 0) ? i_wdata[15:8] : i_wdata[7:0];
          ti = 3'(bofs - `CCT_OFS_CMP_FIRST);
          case (bofs)
            `CCT_OFS_DIR: s_d.dir = bval[3:0];
            `CCT_OFS_OVR_MASK: s_d.ovr_mask = bval[3:0];
            `CCT_OFS_OVR_DATA: s_d.ovr_data = bval[3:0];
            `CCT_OFS_CNT_HI:
            begin
              // R9 counter write only in special mode
              if (s_q.spc_s2)
              begin
                s_d.cnt[15:8] = bval;
                cnt_wr = 1'b1;
              end
            end
            `CCT_OFS_CNT_LO:
            begin
              // R10 low half in the same cycle as high
              if (s_q.spc_s2)
              begin
                s_d.cnt[7:0] = bval;
                cnt_wr = 1'b1;
              end
            end
            `CCT_OFS_CTRL1: s_d.run = bval[`CCT_BIT_RUN];
            `CCT_OFS_TOV: s_d.tov = bval[3:0];
            `CCT_OFS_ACT: s_d.act = bval;
            `CCT_OFS_EDGE: s_d.edge_sel = bval;
            `CCT_OFS_CHMASK: s_d.chmask = bval[3:0];
            `CCT_OFS_CTRL2:
            begin
              s_d.ovie = bval[`CCT_BIT_OVIE];
              s_d.pr = bval[2:0];
            end
            `CCT_OFS_CHFLG: s_d.chflg = s_q.chflg & ~bval[3:0];
            `CCT_OFS_OVFLG: s_d.ovflg = s_q.ovflg & ~bval[`CCT_BIT_OVF];
            default:
            begin
              // R12 compare value write only for output channels
              if (bofs >= `CCT_OFS_CMP_FIRST && bofs <= `CCT_OFS_CMP_LAST && s_q.dir[ti[2:1]])
              begin
                if (ti[0])
                  s_d.cval[ti[2:1]][7:0] = bval;
                else
                  s_d.cval[ti[2:1]][15:8] = bval;
              end
            end
          endcase
        end
      end
    end
    // Capture loads the count, and flags set over clears
    for (int n = 0; n < 4; n++)
    begin
      if (cap[n])
      begin
        s_d.cval[n] = s_q.cnt;
        s_d.chflg[n] = 1'b1;
      end
      // R4 forced action suppresses the flag
      if (match[n] && !fpulse[n])
        s_d.chflg[n] = 1'b1;
    end
    // R17 overflow flag
    if (ovf)
      s_d.ovflg = 1'b1;
    // Level interrupt from unmasked flags
    s_d.irq = |(s_q.chflg & s_q.chmask) || (s_q.ovflg && s_q.ovie);
    // R8 R10 read data, word puts high byte on top
    s_d.rdata = 16'h0000;
    if (blk_sel && i_rd)
    begin
      // R3 force register reads zero through rd_byte default
      if (i_word)
        s_d.rdata = {rd_byte(s_q, ofs), rd_byte(s_q, ofs + 8'h01)};
      else
        s_d.rdata = {8'h00, rd_byte(s_q, ofs)};
    end
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge i_core_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  // Outputs straight from flip-flops
  assign o_rdata = s_q.rdata;
  assign o_cc_pin = s_q.port;
  assign o_cc_pin_oe = s_q.oe;
  assign o_irq = s_q.irq;

  // ****************************************
  // Assertions
  // ****************************************
  // Counter steps onto zero after the last value
  sequence s_wrap_cause;
    s_q.cnt == 16'hffff && tick && !cnt_wr;
  endsequence
  sequence s_wrap_effect;
    s_q.cnt == 16'h0000 && s_q.ovflg;
  endsequence

  property p_wrap;
    @(posedge i_core_clk) disable iff (!i_resetn) s_wrap_cause |=> s_wrap_effect;
  endproperty
  a_wrap: assert property (p_wrap) else $error("counter wrap wrong"); // R17

  property p_force_zero;
    @(posedge i_core_clk) disable iff (!i_resetn)
      (i_rd && blk_sel && i_addr[7:0] == `CCT_OFS_FORCE) |=> o_rdata == 16'h0000;
  endproperty
  a_force_zero: assert property (p_force_zero) else $error("force reads nonzero"); // R3

  property p_force_noflag;
    @(posedge i_core_clk) disable iff (!i_resetn)
      (fpulse[0] && !s_q.chflg[0]) |=> !s_q.chflg[0];
  endproperty
  a_force_noflag: assert property (p_force_noflag) else $error("force set flag"); // R4

  property p_capture;
    @(posedge i_core_clk) disable iff (!i_resetn)
      cap[1] |=> s_q.cval[1] == $past(s_q.cnt) && s_q.chflg[1];
  endproperty
  a_capture: assert property (p_capture) else $error("capture lost"); // R1

  property p_cnt_guard;
    @(posedge i_core_clk) disable iff (!i_resetn)
      (i_wr && !s_q.spc_s2) |=> (s_q.cnt - $past(s_q.cnt)) <= 16'h0001;
  endproperty
  a_cnt_guard: assert property (p_cnt_guard) else $error("counter written in normal mode"); // R9

  property p_tc_ignore;
    @(posedge i_core_clk) disable iff (!i_resetn)
      (!s_q.dir[0] && !cap[0]) |=> $stable(s_q.cval[0]);
  endproperty
  a_tc_ignore: assert property (p_tc_ignore) else $error("capture value overwritten"); // R12

  property p_stop;
    @(posedge i_core_clk) disable iff (!i_resetn)
      (!s_q.run && !cnt_wr) [*2] |=> $stable(s_q.cnt);
  endproperty
  a_stop: assert property (p_stop) else $error("counter ran while stopped"); // R16

  property p_oc3_data;
    @(posedge i_core_clk) disable iff (!i_resetn)
      (match[3] && s_q.ovr_mask[0] && s_q.dir[0] && !(ovf && s_q.tov[0])) |=>
        o_cc_pin[0] == $past(s_q.ovr_data[0]);
  endproperty
  a_oc3_data: assert property (p_oc3_data) else $error("channel 3 data not copied"); // R7

  property p_oe;
    @(posedge i_core_clk) disable iff (!i_resetn)
      (s_q.dir[1] && s_q.ovr_mask[1]) |=> o_cc_pin_oe[1];
  endproperty
  a_oe: assert property (p_oe) else $error("masked pin not driven"); // R6

  property p_irq;
    @(posedge i_core_clk) disable iff (!i_resetn)
      (|(s_q.chflg & s_q.chmask)) |=> o_irq;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt missing");

  // Wrap toggle flips the pin over any other action
  property p_wrap_toggle;
    @(posedge i_core_clk) disable iff (!i_resetn)
      (ovf && s_q.tov[0] && s_q.dir[0]) |=> o_cc_pin[0] == !$past(s_q.port[0]);
  endproperty
  a_wrap_toggle: assert property (p_wrap_toggle) else $error("wrap toggle lost"); // R15

  // Forced set action drives the pin high at once
  property p_force_pin;
    @(posedge i_core_clk) disable iff (!i_resetn)
      (fpulse[0] && s_q.act[1:0] == 2'b11 && !match[3] && !fpulse[3] && !(ovf && s_q.tov[0]))
        |=> o_cc_pin[0];
  endproperty
  a_force_pin: assert property (p_force_pin) else $error("forced action lost"); // R2
endmodule

// ===== tb_cct_timer.sv
`timescale 1ns/1ps
// ****************************************
// Self-checking bench
// ****************************************
module tb_cct_timer;
  import cct_pkg::*;
  logic clk, rstn, word, wr, rd, spc, irq;
  logic [11:0] addr;
  logic [15:0] wdata, rdata, a, b;
  logic [3:0] lvl, pins, ccp, oe;
  int errors, compares;
  // One compare of expected against seen
  `define CHK(n, e, s) chk(n, e, s)
  cct_timer cct_timer_i (.i_core_clk(clk), .i_resetn(rstn), .i_addr(addr), .i_word(word),
    .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .i_special_mode(spc), .i_cc_pin(pins),
    .o_rdata(rdata), .o_cc_pin(ccp), .o_cc_pin_oe(oe), .o_irq(irq));
  cct_pin_model cct_pin_model_i (.i_core_clk(clk), .i_level(lvl), .o_cc_pin(pins));
  // Counts a compare and reports a mismatch
  task chk(input string n, input logic [15:0] e, input logic [15:0] s);
    compares++;
    if (s !== e)
    begin
      $display("unexpected %s: expected %h seen %h", n, e, s);
      errors++;
    end
  endtask
  // Verdict and end of run
  task stop_test;
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // One-cycle write strobe
  task wrr(input logic [11:0] ad, input logic w, input logic [15:0] v);
    @(posedge clk);
    addr <= ad;
    word <= w;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask
  // Read strobe, data taken in the following cycle
  task rdr(input logic [11:0] ad, input logic w, output logic [15:0] v);
    @(posedge clk);
    addr <= ad;
    word <= w;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    v = rdata;
  endtask
  // Bounded wait for the interrupt level
  task wait_irq(input logic lv);
    int i;
    for (i = 0; i < 64 && irq !== lv; i++)
      @(posedge clk) #1;
    if (irq !== lv)
    begin
      $display("unexpected irq wait: expected %h seen %h", lv, irq);
      errors++;
      stop_test();
    end
  endtask
  // Reset values of direction, mask and counter
  task t_reset;
    rdr(12'h220, 1'b0, a);
    `CHK("dir", 16'h0000, a);
    rdr(12'h222, 1'b0, a);
    `CHK("mask", 16'h0000, a);
    rdr(12'h224, 1'b1, a);
    `CHK("counter", 16'h0000, a);
    $display("test reset done");
  endtask
  // Counting, stop, refused and special writes
  task t_count;
    wrr(12'h22b, 1'b0, 16'h0000);
    wrr(12'h226, 1'b0, 16'h0080);
    rdr(12'h224, 1'b1, a);
    rdr(12'h224, 1'b1, b);
    `CHK("count step", 16'h0002, b - a);
    wrr(12'h226, 1'b0, 16'h0000);
    rdr(12'h224, 1'b1, a);
    rdr(12'h224, 1'b1, b);
    `CHK("stopped", a, b);
    wrr(12'h224, 1'b1, 16'h1234);
    rdr(12'h224, 1'b1, b);
    `CHK("normal write", a, b);
    @(posedge clk);
    spc <= 1'b1;
    repeat (3) @(posedge clk);
    wrr(12'h324, 1'b1, 16'h1234);
    rdr(12'h224, 1'b1, a);
    `CHK("word write", 16'h1234, a);
    rdr(12'h225, 1'b0, a);
    `CHK("low byte", 16'h0034, a);
    $display("test count done");
  endtask
  // Forced action drives pin without flag
  task t_force;
    wrr(12'h220, 1'b0, 16'h0001);
    wrr(12'h228, 1'b0, 16'h0003);
    wrr(12'h221, 1'b0, 16'h0001);
    `CHK("forced pin", 16'h0001, {15'h0, ccp[0]});
    `CHK("forced oe", 16'h0001, {15'h0, oe[0]});
    rdr(12'h22c, 1'b0, a);
    `CHK("force flag", 16'h0000, a);
    rdr(12'h321, 1'b0, a);
    `CHK("force read", 16'h0000, a);
    $display("test force done");
  endtask
  // Match, interrupt mask and clear
  task t_match;
    wrr(12'h22e, 1'b1, 16'h123c);
    wrr(12'h228, 1'b0, 16'h0002);
    wrr(12'h22a, 1'b0, 16'h0001);
    wrr(12'h226, 1'b0, 16'h0080);
    wait_irq(1'b1);
    `CHK("match pin", 16'h0000, {15'h0, ccp[0]});
    rdr(12'h22c, 1'b0, a);
    `CHK("match flag", 16'h0001, a);
    wrr(12'h22a, 1'b0, 16'h0000);
    wait_irq(1'b0);
    wrr(12'h22a, 1'b0, 16'h0001);
    wait_irq(1'b1);
    wrr(12'h22c, 1'b0, 16'h0001);
    wait_irq(1'b0);
    rdr(12'h22c, 1'b0, a);
    `CHK("cleared flag", 16'h0000, a);
    $display("test match done");
  endtask
  // Channel 3 match overrides channel 0 in the same cycle
  task t_ch3;
    wrr(12'h226, 1'b0, 16'h0000);
    wrr(12'h224, 1'b1, 16'h2000);
    wrr(12'h220, 1'b0, 16'h0009);
    wrr(12'h22e, 1'b1, 16'h2008);
    wrr(12'h234, 1'b1, 16'h2008);
    wrr(12'h222, 1'b0, 16'h0001);
    wrr(12'h223, 1'b0, 16'h0001);
    wrr(12'h22a, 1'b0, 16'h0008);
    wrr(12'h226, 1'b0, 16'h0080);
    wait_irq(1'b1);
    `CHK("override pin", 16'h0001, {15'h0, ccp[0]});
    $display("test ch3 done");
  endtask
  // Toggle action, divided tick, wrap flag and wrap toggle
  task t_wrap;
    wrr(12'h226, 1'b0, 16'h0000);
    wrr(12'h22a, 1'b0, 16'h0000);
    wrr(12'h228, 1'b0, 16'h0001);
    wrr(12'h221, 1'b0, 16'h0001);
    `CHK("toggle pin", 16'h0000, {15'h0, ccp[0]});
    wrr(12'h227, 1'b0, 16'h0001);
    wrr(12'h22b, 1'b0, 16'h0081);
    wrr(12'h224, 1'b1, 16'hfffe);
    wrr(12'h226, 1'b0, 16'h0080);
    wait_irq(1'b1);
    `CHK("wrap toggle", 16'h0001, {15'h0, ccp[0]});
    rdr(12'h22d, 1'b0, a);
    `CHK("wrap flag", 16'h0080, a);
    $display("test wrap done");
  endtask
  // Capture channel refuses writes and captures an edge
  task t_capture;
    wrr(12'h22a, 1'b0, 16'h0002);
    wrr(12'h230, 1'b1, 16'hbeef);
    rdr(12'h230, 1'b1, a);
    `CHK("capture write", 16'h0000, a);
    wrr(12'h229, 1'b0, 16'h0004);
    lvl <= 4'h2;
    wait_irq(1'b1);
    rdr(12'h22c, 1'b0, a);
    `CHK("capture flag", 16'h0002, a & 16'h0002);
    $display("test capture done");
  endtask
  // Clock source
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Main sequence
  initial
  begin
    errors = 0;
    compares = 0;
    rstn = 1'b0;
    {word, wr, rd, spc} = 4'h0;
    addr = 12'h000;
    wdata = 16'h0000;
    lvl = 4'h0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    t_reset();
    t_count();
    t_force();
    t_match();
    t_ch3();
    t_capture();
    t_wrap();
    stop_test();
  end
endmodule
